// [src/strv_pkg.sv]
// Constants and carrier types for the scram trip voting and reset block
// What this block does
// RL1: Run-mode bus loss vote starts short scram delay
// RL2: Full manual scram needs both switches
// RL3: Manual switches act on divisions 1, 2
// RL4: Power-out division half-scrams; other switch completes
// RL5: Non-power outage, divisions 3/4 leave manual
// RL6: Divisional manual switch trips its actuators
// RL7: Two divisional manual switches cause scram
// RL8: One reset clears manual scram both divisions
// RL9: Divisional reset clears that division seal-in
// RL10: Reset ignored while trip cause persists
// RL11: All resets blocked ten seconds after scram
// RL12: Manual reset re-energises groups in sequence
// RL13: Charging pressure trip blocks reset unless bypassed
// RL14: Pool temperature high in two channels scrams
// RL15: Exposed pool sensors excluded from average
// RL16: Two auto or both manual cut solenoids
// RL17: Same trip opens both air dump valves
// RL18: Run indication per division to monitor
// RL19: Scram-follow, test status, mode to rods
// RL20: Rod block on pressure trip or bypass
// RL21: Not-Run bypass interlock to leak detection
// RL22: Low trip oil pressure means valve closure
// RL23: Delays are synchronous counters with constants
package strv_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BUS_LOSS_DELAY_MS = 500;
  localparam int unsigned RESET_INHIBIT_MS = 10000;
  localparam int unsigned GROUP_STEP_MS = 100;
  localparam int unsigned BUS_LOSS_CYCLES = BUS_LOSS_DELAY_MS * CLK_MHZ * 1000;
  localparam int unsigned RESET_INHIBIT_CYCLES = RESET_INHIBIT_MS * CLK_MHZ * 1000;
  localparam int unsigned GROUP_STEP_CYCLES = GROUP_STEP_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------
  // Analog thresholds (digitised 16-bit codes)
  // ----------------------------------------------------------------
  localparam logic [15:0] OIL_LOW_DEFAULT = 16'h2000;
  localparam logic [15:0] POOL_HIGH_DEFAULT = 16'h4000;
  localparam int unsigned POOL_SENSORS = 4;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OIL_LIMIT = 8'h04;
  localparam logic [7:0] REG_POOL_LIMIT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TRIPS = 8'h10;
  localparam int unsigned CTRL_TEST_POS = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Mode switch positions
  typedef enum logic [1:0] {
    STRV_MODE_SHUTDOWN = 2'b00,
    STRV_MODE_REFUEL = 2'b01,
    STRV_MODE_STARTUP = 2'b10,
    STRV_MODE_RUN = 2'b11
  } strv_mode_t;

  // Manual reset sequencer states
  typedef enum logic [1:0] {
    STRV_SEQ_IDLE = 2'b00,
    STRV_SEQ_GROUP_A = 2'b01,
    STRV_SEQ_GROUP_B = 2'b10
  } strv_seq_t;

  // Outputs to rod control
  typedef struct packed {
    logic scram_follow;
    logic pair_rod_test;
    strv_mode_t mode;
    logic [3:0] rod_block;
  } strv_rod_t;

  // Actuator outputs
  typedef struct packed {
    logic [1:0] solenoid_power;
    logic [1:0] air_dump;
  } strv_act_t;

endpackage

// [src/strv_timer.sv]
// Synchronous delay counter: done after a fixed run of enabled cycles
module strv_timer #(
  parameter logic [31:0] TERMINAL = 32'h0000_0001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic done
);

  logic [strv_pkg::CNT_W-1:0] count;

  // Counts while run holds; clears when run drops, so a blip never accumulates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (count != TERMINAL) begin
      count <= count + 32'h0000_0001; // RL23
    end
  end

  assign done = run && (count == TERMINAL);

endmodule

// [src/strv_top.sv]
// Scram trip voting, seal-in and reset logic with AXI4-Lite setup registers
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
module strv_top #(
  parameter logic [31:0] BUS_LOSS_CYCLES = strv_pkg::BUS_LOSS_CYCLES,
  parameter logic [31:0] RESET_INHIBIT_CYCLES = strv_pkg::RESET_INHIBIT_CYCLES,
  parameter logic [31:0] GROUP_STEP_CYCLES = strv_pkg::GROUP_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [3:0] bus_low_voltage,
  input wire logic [3:0] stop_valve_closure,
  input wire logic [63:0] oil_pressure,
  input wire logic [3:0] sensor_trip,
  input wire logic [3:0] charging_low,
  input wire logic [3:0] charging_bypass,
  input wire logic [63:0] pool_temp,
  input wire logic [3:0] pool_submerged,
  input wire logic [1:0] manual_scram_sw,
  input wire logic [1:0] power_out_of_service,
  input wire logic [3:0] div_manual_trip_sw,
  input wire logic manual_reset_sw,
  input wire logic [3:0] div_reset_sw,
  input wire logic [1:0] mode_sw,
  input wire logic pair_rod_test_sw,
  output strv_pkg::strv_act_t actuators,
  output strv_pkg::strv_rod_t rod_control,
  output logic [3:0] run_to_neutron_monitor,
  output logic isolation_bypass
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 40;
  logic [SW-1:0] pin_raw, pin_s1, pin_s2;
  logic [1:0] prime;
  assign pin_raw = {bus_low_voltage, stop_valve_closure, sensor_trip, charging_low, charging_bypass,
                    pool_submerged, manual_scram_sw, power_out_of_service, div_manual_trip_sw,
                    manual_reset_sw, div_reset_sw, mode_sw, pair_rod_test_sw};

  // Two stages before any logic; stage one is read by stage two only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      prime <= 2'b00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      prime <= {prime[0], 1'b1};
    end
  end

  logic [3:0] bus_low, svc, s_trip, chg_low, chg_byp, submerged, dm_sw, dr_sw;
  logic [1:0] man_sw, pwr_oos, mode_q;
  logic man_rst, rod_test;
  assign {bus_low, svc, s_trip, chg_low, chg_byp, submerged, man_sw, pwr_oos, dm_sw,
          man_rst, dr_sw, mode_q, rod_test} = pin_s2;

  // Analog words come from the same-clock digitiser, so they need no synchroniser
  logic [63:0] oil_q, pool_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oil_q <= '0;
      pool_q <= '0;
    end else begin
      oil_q <= oil_pressure;
      pool_q <= pool_temp;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, oil_limit, pool_limit;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic full_scram, half_scram, inhibit_active;
  logic [3:0] div_trip, div_seal;
  logic [1:0] man_latch;

  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready = !w_held && !s_bvalid;
  wire aw_now = aw_held || (s_awvalid && s_awready);
  wire w_now = w_held || (s_wvalid && s_wready);
  wire [7:0] wr_addr = aw_held ? aw_addr : s_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_wstrb;
  wire wr_fire = aw_now && w_now && !s_bvalid;
  wire wr_ctrl = wr_addr == strv_pkg::REG_CTRL;
  wire wr_oil = wr_addr == strv_pkg::REG_OIL_LIMIT;
  wire wr_pool = wr_addr == strv_pkg::REG_POOL_LIMIT;
  wire wr_hit = wr_ctrl || wr_oil || wr_pool;

  function automatic logic [31:0] strv_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Address and data may come in either order; the response waits for both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_bvalid <= 1'b0;
      s_bresp <= strv_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) aw_addr <= s_awaddr;
      if (s_wvalid && s_wready) begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      aw_held <= wr_fire ? 1'b0 : aw_now;
      w_held <= wr_fire ? 1'b0 : w_now;
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? strv_pkg::RESP_OKAY : strv_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Setup registers; thresholds are software-trimmable, status is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= strv_pkg::CTRL_RESET;
      oil_limit <= {16'h0000, strv_pkg::OIL_LOW_DEFAULT};
      pool_limit <= {16'h0000, strv_pkg::POOL_HIGH_DEFAULT};
    end else if (wr_fire) begin
      if (wr_ctrl && wr_strb[0]) ctrl_reg <= {31'h0, wr_data[0]};
      if (wr_oil) oil_limit <= strv_merge(oil_limit, wr_data, {2'b00, wr_strb[1:0]}); // Upper half stays zero
      if (wr_pool) pool_limit <= strv_merge(pool_limit, wr_data, {2'b00, wr_strb[1:0]});
    end
  end

  assign s_arready = !s_rvalid;
  wire [31:0] status_word = {24'h0, inhibit_active, half_scram, full_scram, man_latch, mode_q, 1'b0};
  wire [31:0] trips_word = {24'h0, div_seal, div_trip};
  wire rd_hit = (s_araddr == strv_pkg::REG_CTRL) || (s_araddr == strv_pkg::REG_OIL_LIMIT) ||
                (s_araddr == strv_pkg::REG_POOL_LIMIT) || (s_araddr == strv_pkg::REG_STATUS) ||
                (s_araddr == strv_pkg::REG_TRIPS);
  wire [31:0] rd_word = (s_araddr == strv_pkg::REG_CTRL) ? ctrl_reg :
                        (s_araddr == strv_pkg::REG_OIL_LIMIT) ? oil_limit :
                        (s_araddr == strv_pkg::REG_POOL_LIMIT) ? pool_limit :
                        (s_araddr == strv_pkg::REG_STATUS) ? status_word :
                        (s_araddr == strv_pkg::REG_TRIPS) ? trips_word : 32'h0000_0000;

  // Read answer registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= strv_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= rd_hit ? strv_pkg::RESP_OKAY : strv_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-division trip conditions
  // ----------------------------------------------------------------
  wire in_run = mode_q == strv_pkg::STRV_MODE_RUN;
  logic [3:0] oil_low, pool_high;
  logic [17:0] pool_sum [4];
  logic [2:0] pool_cnt [4];

  // Pool channels average only submerged sensors; exposed ones drop out
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      assign oil_low[g] = oil_q[g*16 +: 16] < oil_limit[15:0]; // RL22
      assign pool_sum[g] = submerged[g] ? {2'b00, pool_q[g*16 +: 16]} : 18'h00000; // RL15
      assign pool_cnt[g] = {2'b00, submerged[g]}; // RL15
    end
  endgenerate

  // Each channel compares against limit: sensor average taken across submerged channels
  wire [17:0] sum_all = pool_sum[0] + pool_sum[1] + pool_sum[2] + pool_sum[3];
  wire [2:0] cnt_all = pool_cnt[0] + pool_cnt[1] + pool_cnt[2] + pool_cnt[3];
  wire [17:0] lim_scaled = {2'b00, pool_limit[15:0]} * {15'h0, cnt_all};
  generate
    for (g = 0; g < 4; g++) begin : g_pool
      assign pool_high[g] = submerged[g] && (cnt_all != 3'h0) && (sum_all > lim_scaled);
    end
  endgenerate

  function automatic logic strv_two_of_four(input logic [3:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[0] & v[3]) | (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
  endfunction

  // Bus loss vote only counts in Run; delay spans the transfer to the reserve feed
  wire bus_vote = in_run && strv_two_of_four(bus_low); // RL1
  logic bus_loss_trip;
  strv_timer #(.TERMINAL(BUS_LOSS_CYCLES)) u_bus_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(bus_vote),
    .done(bus_loss_trip)
  );

  wire pool_trip = strv_two_of_four(pool_high); // RL14
  wire [3:0] chg_trip = chg_low & ~chg_byp;
  // A division's cause: sensor trips, valves, oil pressure, pool, bus loss, charging pressure, Shutdown mode
  wire [3:0] div_cause = s_trip | svc | oil_low | chg_trip | {4{pool_trip | bus_loss_trip}} |
                         {4{mode_q == strv_pkg::STRV_MODE_SHUTDOWN}};
  assign div_trip = div_cause | dm_sw; // RL6

  // ----------------------------------------------------------------
  // Seal-in and resets
  // ----------------------------------------------------------------
  logic inhibit_done;
  strv_timer #(.TERMINAL(RESET_INHIBIT_CYCLES)) u_inhibit (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(inhibit_active),
    .done(inhibit_done)
  );

  // Charging pressure low blocks every reset until bypassed in all four
  wire chg_block = |chg_low && !(&chg_byp); // RL13
  wire reset_ok = !inhibit_active && !chg_block; // RL11
  logic [3:0] next_seal;
  assign next_seal = div_trip | (div_seal & ~(dr_sw & ~div_trip & {4{reset_ok}})); // RL9 RL10

  // Manual path: switches act on divisions 1 and 2 only, power outage counts as tripped
  wire [1:0] man_eff = man_sw | man_latch | pwr_oos; // RL3 RL4 RL5
  strv_pkg::strv_seq_t seq;
  logic [strv_pkg::CNT_W-1:0] seq_cnt;
  wire seq_step = seq_cnt == GROUP_STEP_CYCLES;
  wire man_reset_go = man_rst && reset_ok && !(|man_sw); // RL8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_seal <= 4'h0;
      man_latch <= 2'b00;
    end else begin
      if (prime[1]) div_seal <= next_seal; // Syncs still at reset zeros read as Shutdown
      if (seq == strv_pkg::STRV_SEQ_GROUP_A) man_latch[0] <= man_sw[0];
      else if (seq == strv_pkg::STRV_SEQ_GROUP_B && seq_step) man_latch[1] <= man_sw[1]; // RL12
      else man_latch <= man_latch | man_sw;
    end
  end

  // Reset sequencer: group A first, group B a step later, never both together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq <= strv_pkg::STRV_SEQ_IDLE;
      seq_cnt <= '0;
    end else begin
      unique case (seq)
        strv_pkg::STRV_SEQ_IDLE: begin
          seq_cnt <= '0;
          if (man_reset_go && (|man_latch)) seq <= strv_pkg::STRV_SEQ_GROUP_A; // RL12
        end
        strv_pkg::STRV_SEQ_GROUP_A: begin
          seq <= strv_pkg::STRV_SEQ_GROUP_B;
        end
        strv_pkg::STRV_SEQ_GROUP_B: begin
          seq_cnt <= seq_cnt + 32'h0000_0001;
          if (seq_step) seq <= strv_pkg::STRV_SEQ_IDLE;
        end
        default: seq <= strv_pkg::STRV_SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scram decision and inhibit timing
  // ----------------------------------------------------------------
  wire auto_scram = strv_two_of_four(div_seal); // RL16 RL7
  wire man_scram = &man_eff; // RL2 RL16
  assign full_scram = auto_scram || man_scram;
  assign half_scram = ^man_eff; // RL4
  logic scram_q;

  // Inhibit runs ten seconds from the rising edge of any full scram
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scram_q <= 1'b0;
      inhibit_active <= 1'b0;
    end else begin
      scram_q <= full_scram;
      if (full_scram && !scram_q) inhibit_active <= 1'b1; // RL11
      else if (inhibit_done) inhibit_active <= 1'b0;
    end
  end

  // Outputs are registered; on full scram solenoids de-energise and dump valves open together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      actuators <= '0;
      rod_control <= '0;
      run_to_neutron_monitor <= 4'h0;
      isolation_bypass <= 1'b0;
    end else begin
      actuators.solenoid_power <= {!full_scram && !man_eff[1], !full_scram && !man_eff[0]}; // RL16
      actuators.air_dump <= {2{full_scram}}; // RL17
      rod_control.scram_follow <= full_scram; // RL19
      rod_control.pair_rod_test <= rod_test | ctrl_reg[strv_pkg::CTRL_TEST_POS]; // RL19
      rod_control.mode <= strv_pkg::strv_mode_t'(mode_q); // RL19
      rod_control.rod_block <= chg_low | chg_byp; // RL20
      run_to_neutron_monitor <= {4{in_run}}; // RL18
      isolation_bypass <= !in_run; // RL21
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_dump_with_cut;
    @(posedge aclk) disable iff (!aresetn) full_scram |=> (actuators.air_dump == 2'b11 &&
                                                          actuators.solenoid_power == 2'b00);
  endproperty
  scram_cuts_power_a: assert property (p_dump_with_cut) else $error("scram did not cut power"); // RL16
  dump_matches_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (actuators.air_dump == 2'b11) == (actuators.solenoid_power == 2'b00) || actuators.air_dump == 2'b00)
    else $error("dump valves and solenoids disagree"); // RL17
  two_manual_scram_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (&man_eff) |=> (actuators.solenoid_power == 2'b00 && rod_control.scram_follow))
    else $error("both manual channels did not scram"); // RL2
  seal_hold_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (prime[1] && div_trip[0]) |=> div_seal[0]) else $error("tripped division not sealed"); // RL10
  inhibit_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (inhibit_active && div_seal[1] && !div_trip[1]) |=> div_seal[1]) else $error("reset during inhibit"); // RL11
  charging_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (chg_block && div_seal[2]) |=> div_seal[2]) else $error("reset with charging trip"); // RL13
  rod_block_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (|chg_byp[0]) |=> rod_control.rod_block[0]) else $error("rod block missing"); // RL20
  run_indicate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_run |=> (run_to_neutron_monitor == 4'hf && !isolation_bypass)) else $error("run indication wrong"); // RL18
  seq_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (man_latch == 2'b11) |=> (man_latch != 2'b00))
    else $error("reset groups out of order"); // RL12
  cover_auto_c: cover property (@(posedge aclk) disable iff (!aresetn) auto_scram);
  cover_manual_c: cover property (@(posedge aclk) disable iff (!aresetn) man_scram && !auto_scram);
  cover_bus_c: cover property (@(posedge aclk) disable iff (!aresetn) bus_loss_trip);
  cover_reset_c: cover property (@(posedge aclk) disable iff (!aresetn) seq == strv_pkg::STRV_SEQ_GROUP_B);

endmodule

// [sim/strv_plant_model.sv]
// Plant model: digitised oil pressure and pool temperature words
module strv_plant_model (
  input wire logic aclk,
  input wire logic [3:0] oil_low,
  input wire logic [3:0] pool_hot,
  output logic [63:0] oil_pressure,
  output logic [63:0] pool_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Transmitter readings
  // ----------------------------------------------------------------
  // Noise stays below 16'h1000 so a word never crosses its limit by chance
  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      oil_pressure[16*i +: 16] <= (oil_low[i] ? 16'h1000 : 16'h3000) + 16'($urandom_range(0, 4095));
      pool_temp[16*i +: 16] <= (pool_hot[i] ? 16'h5000 : 16'h2000) + 16'($urandom_range(0, 4095));
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the scram trip voting and reset block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, obs = 0, man_rst = 0;
  logic [7:0] s_awaddr = '0, s_araddr = '0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, byp;
  logic [1:0] s_bresp, s_rresp, man_sw = '0, pos = '0, mode = 2'h3;
  logic [3:0] bus_lv = '0, chg_low = '0, chg_byp = '0, sub = 4'hf, div_trip = '0, div_rst = '0, run_nm;
  logic [3:0] oil_low = '0, pool_hot = '0, svc = '0, s_trip = '0;
  logic [63:0] oil, pool;
  strv_pkg::strv_act_t act;
  strv_pkg::strv_rod_t rod;
  logic [34:0] q[$];
  logic [34:0] nt;
  int n_mismatch = 0, compares = 0;

  always #2.5 aclk = ~aclk;

  strv_plant_model u_plant (.aclk(aclk), .oil_low(oil_low), .pool_hot(pool_hot), .oil_pressure(oil), .pool_temp(pool));

  // Short counts keep the whole run to under fifteen hundred cycles
  strv_top #(.BUS_LOSS_CYCLES(32'h14), .RESET_INHIBIT_CYCLES(32'h32), .GROUP_STEP_CYCLES(32'ha)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .bus_low_voltage(bus_lv),
    .stop_valve_closure(svc), .oil_pressure(oil), .sensor_trip(s_trip), .charging_low(chg_low),
    .charging_bypass(chg_byp), .pool_temp(pool), .pool_submerged(sub), .manual_scram_sw(man_sw),
    .power_out_of_service(pos), .div_manual_trip_sw(div_trip), .manual_reset_sw(man_rst), .div_reset_sw(div_rst),
    .mode_sw(mode), .pair_rod_test_sw(1'h0), .actuators(act), .rod_control(rod), .run_to_neutron_monitor(run_nm),
    .isolation_bypass(byp));

  // ----------------------------------------------------------------
  // Verdict and comparisons
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic fail_out();
    n_mismatch++;
    report_and_stop();
  endtask

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] read resp_data expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] write resp expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_out(input logic [16:0] e, input logic [16:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] outputs expected %h seen %h", e, s);
    end
  endtask

  // Monitor: each result takes the oldest note off the queue
  always @(posedge aclk) begin
    if ((s_rvalid && s_rready) || (s_bvalid && s_bready) || obs) begin
      if (q.size() == 0) fail_out();
      nt = q.pop_front();
      if (nt[34]) cmp_out(nt[16:0], {act, run_nm, byp, rod});
      else if (s_bvalid) cmp_wr(nt[33:32], s_bresp);
      else cmp_rd(nt[33:0], {s_rresp, s_rdata});
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Flags are looked at mid-cycle, where they have settled; returns on the taking edge
  task automatic wait_hi(ref logic f);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (f !== 1'h1 && n < 100);
    if (f !== 1'h1) fail_out();
    @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    q.push_back({1'h0, r, 32'h0});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    repeat (100) begin
      if (!(ta && tw)) begin
        @(negedge aclk);
        ta = ta | (s_awvalid & s_awready);
        tw = tw | (s_wvalid & s_wready);
        @(posedge aclk);
        if (ta) s_awvalid <= 0;
        if (tw) s_wvalid <= 0;
      end
    end
    if (!(ta && tw)) fail_out();
    s_bready <= 1;
    wait_hi(s_bvalid);
    s_bready <= 0;
    cyc(1);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back({1'h0, e});
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    wait_hi(s_arready);
    s_arvalid <= 0;
    wait_hi(s_rvalid);
    s_rready <= 0;
    cyc(1);
  endtask

  // Inputs pass two sync stages and an output register before they show
  task automatic chk(input logic [16:0] e);
    cyc(8);
    q.push_back({1'h1, 17'h0, e});
    obs <= 1;
    cyc(1);
    obs <= 0;
  endtask

  // Run mode outputs for a given solenoid state and rod block
  function automatic logic [16:0] ev(input logic [1:0] s, input logic [3:0] rb);
    return {s, (s == 2'h0) ? 2'h3 : 2'h0, 4'hf, 1'h0, s == 2'h0, 3'h3, rb};
  endfunction

  // Waits out the inhibit, then presses every reset switch
  task automatic recover();
    cyc(60);
    man_rst <= 1;
    div_rst <= 4'hf;
    cyc(4);
    man_rst <= 0;
    div_rst <= 4'h0;
    cyc(40);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(76380));
    cyc(3);
    aresetn <= 1;
    cyc(8);
    axi_rd(8'h04, {2'h0, 32'h2000});
    axi_rd(8'h08, {2'h0, 32'h4000});
    axi_rd(8'h20, {2'h2, 32'h0});
    axi_wr(8'h20, 32'h1, 2'h2);
    axi_wr(8'h00, 32'h1, 2'h0);
    axi_rd(8'h00, {2'h0, 32'h1});
    chk(ev(2'h3, 4'h0) | 17'h00040);
    axi_wr(8'h00, 32'h0, 2'h0);
    chk(ev(2'h3, 4'h0));
    mode <= 2'h2;
    chk({2'h3, 2'h0, 4'h0, 1'h1, 1'h0, 3'h2, 4'h0});
    mode <= 2'h0;
    chk({2'h0, 2'h3, 4'h0, 1'h1, 1'h1, 3'h0, 4'h0});
    mode <= 2'h3;
    recover();
    man_sw <= 2'h1;
    chk(ev(2'h2, 4'h0));
    man_sw <= 2'h3;
    chk(ev(2'h0, 4'h0));
    man_sw <= 2'h0;
    man_rst <= 1;
    cyc(4);
    man_rst <= 0;
    chk(ev(2'h0, 4'h0));
    recover();
    chk(ev(2'h3, 4'h0));
    pos <= 2'h2;
    chk(ev(2'h1, 4'h0));
    man_sw <= 2'h1;
    chk(ev(2'h0, 4'h0));
    man_sw <= 2'h0;
    pos <= 2'h0;
    recover();
    div_trip <= 4'h1;
    chk(ev(2'h3, 4'h0));
    div_trip <= 4'h5;
    chk(ev(2'h0, 4'h0));
    div_trip <= 4'h0;
    recover();
    chk(ev(2'h3, 4'h0));
    bus_lv <= 4'h3;
    chk(ev(2'h3, 4'h0));
    cyc(20);
    chk(ev(2'h0, 4'h0));
    bus_lv <= 4'h0;
    recover();
    oil_low <= 4'h3;
    chk(ev(2'h0, 4'h0));
    oil_low <= 4'h0;
    recover();
    s_trip <= 4'h8;
    chk(ev(2'h3, 4'h0));
    svc <= 4'h2;
    chk(ev(2'h0, 4'h0));
    s_trip <= 4'h0;
    svc <= 4'h0;
    recover();
    pool_hot <= 4'h7;
    sub <= 4'h8;
    chk(ev(2'h3, 4'h0));
    sub <= 4'hf;
    chk(ev(2'h0, 4'h0));
    pool_hot <= 4'h0;
    recover();
    chg_low <= 4'hf;
    chk(ev(2'h0, 4'hf));
    recover();
    chk(ev(2'h0, 4'hf));
    chg_byp <= 4'hf;
    recover();
    chk(ev(2'h3, 4'hf));
    chg_low <= 4'h0;
    chg_byp <= 4'h0;
    chk(ev(2'h3, 4'h0));
    report_and_stop();
  end

  // Watchdog against a hang anywhere in the sequence
  initial begin
    cyc(30000);
    fail_out();
  end
endmodule
